// [verilog/arxf_pkg.sv]
// arxf_pkg: op-codes, control fields, counts and reset values of the
// receiver-2 filter and host read decode.
// assumes a host serial master that sends one op-code byte per frame.
//
// What this block does
// - Op-code 0xb4 returns one byte, the receiver-2 control register.
// - Op-code 0xb8 returns 32 bytes of receiver-2 label acceptance memory.
// - Op-code 0xbc returns the three receiver-2 priority match labels.
// - Op-code 0xc0 returns four bytes, one whole word from the FIFO.
// - Op-codes 0xc4, 0xc8, 0xcc return mailbox 1, 2, 3 bits 9 to 32.
// - Op-code 0xd0 returns the flag and interrupt assignment byte.
// - Op-code 0xd4 returns the reference clock division byte.
// - Op-code 0xff does nothing and moves no data bytes.
// - Control written by 0x10, read by 0x94 (rx1); written by 0x24 (rx2).
// - Control bit 7 reverses the first eight bits of each received word.
// - With decoding on, word bit 9 must equal control bit 6.
// - With decoding on, word bit 10 must equal control bit 5.
// - Control bit 4 turns decoding on; when off bits 9, 10 are ignored.
// - Parity bit set checks word parity; clear stores all 32 bits.
// - Control bit 2 set stores only words whose label bit is one.
// - Control bit 1 set captures label matches that pass decoding and parity into the matching mailbox.
// - Control bit 1 clear: no matching and no mailbox writes.
// - Control bit 0 picks line rate: zero high, one low (high over 8).
// - Label bytes start at label 0xff, descending, high bit first.
// - Match bytes go filter 3 first, then filter 2, then filter 1.
package arxf_pkg;
  // host op-codes
  localparam logic [7:0] OP_WR_RX1_CTL = 8'h10;
  localparam logic [7:0] OP_WR_RX2_CTL = 8'h24;
  localparam logic [7:0] OP_WR_LABELS = 8'h28;
  localparam logic [7:0] OP_WR_MATCH = 8'h2c;
  localparam logic [7:0] OP_WR_FLAGS = 8'h34;
  localparam logic [7:0] OP_WR_DIVIDE = 8'h38;
  localparam logic [7:0] OP_RD_RX1_CTL = 8'h94;
  localparam logic [7:0] OP_RD_RX2_CTL = 8'hb4;
  localparam logic [7:0] OP_RD_LABELS = 8'hb8;
  localparam logic [7:0] OP_RD_MATCH = 8'hbc;
  localparam logic [7:0] OP_RD_MESSAGE = 8'hc0;
  localparam logic [7:0] OP_RD_MBOX1 = 8'hc4;
  localparam logic [7:0] OP_RD_MBOX2 = 8'hc8;
  localparam logic [7:0] OP_RD_MBOX3 = 8'hcc;
  localparam logic [7:0] OP_RD_FLAGS = 8'hd0;
  localparam logic [7:0] OP_RD_DIVIDE = 8'hd4;
  localparam logic [7:0] OP_NOP = 8'hff;
  // data bytes per op-code
  localparam logic [5:0] CTL_BYTES = 6'h01;
  localparam logic [5:0] LABEL_BYTES = 6'h20;
  localparam logic [5:0] MATCH_BYTES = 6'h03;
  localparam logic [5:0] MESSAGE_BYTES = 6'h04;
  localparam logic [5:0] MBOX_BYTES = 6'h03;
  // receiver control register fields
  localparam int CTL_RX_LABEL_BIT_REVERSE = 7;
  localparam int CTL_MATCH_VALUE_BIT_NINE = 6;
  localparam int CTL_MATCH_VALUE_BIT_TEN = 5;
  localparam int CTL_SRC_DEST_DECODE_ENABLE = 4;
  localparam int CTL_PARITY_CHECK = 3;
  localparam int CTL_LABEL_FILTER_ENABLE = 2;
  localparam int CTL_PRIORITY_CAPTURE_ENABLE = 1;
  localparam int CTL_LOW_RATE = 0;
  // message bit positions (message bit n sits at index n-1)
  localparam int MSG_BIT_NINE = 8;
  localparam int MSG_BIT_TEN = 9;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DIVIDE_RESET = 8'h00;
  // synchronised pin slots and their idle levels
  localparam int PIN_SCK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_MOSI = 2;
  localparam logic [2:0] PIN_IDLE = 3'h2;
endpackage

// [verilog/arxf_fifo.sv]
// arxf_fifo: small synchronous word FIFO with valid/ready on both sides.
// assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
module arxf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } arxf_fifo_state_type;

  arxf_fifo_state_type state, next_state;
  logic push, pop;

  // honest flags straight from the fill count
  assign inReady = (state.count != FULL);
  assign outValid = (state.count != '0);
  assign outData = state.mem[state.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointer and count update; push and pop may share a cycle
  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wrPtr] = inData;
      next_state.wrPtr = state.wrPtr + 1'b1;
    end
    if (pop) begin
      next_state.rdPtr = state.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule // arxf_fifo

// [verilog/arxf_label_mem.sv]
// arxf_label_mem: label acceptance bits, one write and two read ports.
// assumes a read address held one cycle before its data is used.
`timescale 1ns/1ps
module arxf_label_mem #(
  parameter int ENTRIES = 32,
  parameter int BITS = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host write port
  input wire logic wrEn,
  input wire logic [$clog2(ENTRIES)-1:0] wrAddr,
  input wire logic [BITS-1:0] wrData,
  // host read port
  input wire logic [$clog2(ENTRIES)-1:0] rdAddrA,
  output logic [BITS-1:0] rdDataA,
  // filter lookup port
  input wire logic [$clog2(ENTRIES)-1:0] rdAddrB,
  output logic [BITS-1:0] rdDataB
);
  typedef struct packed {
    logic [ENTRIES-1:0][BITS-1:0] mem;
    logic [BITS-1:0] dataA;
    logic [BITS-1:0] dataB;
  } arxf_mem_state_type;

  arxf_mem_state_type state, next_state;

  assign rdDataA = state.dataA;
  assign rdDataB = state.dataB;

  // registered reads see the contents before this cycle's write
  always_comb begin
    next_state = state;
    next_state.dataA = state.mem[rdAddrA];
    next_state.dataB = state.mem[rdAddrB];
    if (wrEn) begin
      next_state.mem[wrAddr] = wrData;
    end
  end

  // state register; every label starts rejected
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule // arxf_label_mem

// [verilog/arxf_rx_filter_control.sv]
// arxf_rx_filter_control: host serial op-code decode, receiver control
// registers and the receiver-2 acceptance filter feeding an 8-word FIFO.
// assumes a mode-0 serial master (sample on rising clock, MSB first) with
// its clock far slower than ref_clk, and decoded words from a line decoder.
`timescale 1ns/1ps
module arxf_rx_filter_control
  import arxf_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host serial port pins
  input wire logic spiClk,
  input wire logic spiSelectN,
  input wire logic spiMosi,
  output logic spiMisoOut,
  output logic spiMisoOeN,
  // decoded words from the receiver-2 line decoder
  input wire logic [31:0] rxWord,
  input wire logic rxWordValid,
  output logic rxWordReady,
  // settings for the rest of the chip
  output logic [7:0] rx1Control,
  output logic rx2LowSpeed,
  output logic [7:0] flagAssign,
  output logic [7:0] clockDivide
);
  typedef enum logic [1:0] {
    SP_OPCODE = 2'b01,
    SP_DATA = 2'b10
  } arxf_spi_phase_type;
  typedef enum logic [2:0] {
    FL_EMPTY = 3'b001,
    FL_CHECK = 3'b010,
    FL_PUSH = 3'b100
  } arxf_filt_phase_type;
  typedef struct packed {
    logic [2:0][2:0] sync;
    logic [2:0] lvl;
    arxf_spi_phase_type phase;
    logic [2:0] bitCnt;
    logic [5:0] dataIdx;
    logic [6:0] rxShift;
    logic [7:0] opcode;
    logic [7:0] txByte;
    logic misoOut;
    logic misoOeN;
    logic [31:0] msgHold;
    logic [7:0] rx1Ctl;
    logic [7:0] rx2Ctl;
    logic [2:0][7:0] match;
    logic [2:0][23:0] mbox;
    logic [7:0] flags;
    logic [7:0] divide;
    arxf_filt_phase_type filt;
    logic [31:0] word;
  } arxf_main_state_type;
  arxf_main_state_type state, next_state;
  logic [2:0] pinIn;
  logic sckRise, sckFall, selected, mosiBit;
  logic [7:0] fullByte, labelRdA, labelRdB, inLabel, rxLabelIn;
  logic memWrEn;
  logic [4:0] memWrAddr, memAddrA, memAddrB;
  logic [7:0] memWrData;
  logic fifoInReady, fifoOutValid, fifoPop;
  logic [31:0] fifoOutData;
  logic sdOk, parityOk, labelOk, acceptWord;
  logic [23:0] wordHigh;
  // bit order swap of a label byte
  function automatic logic [7:0] flipByte(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction
  // byte n of a word, most significant byte first
  function automatic logic [7:0] wordByte(input logic [31:0] w,
                                          input logic [1:0] n);
    logic [7:0] b;
    b = 8'h00;
    unique case (n)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
    endcase
    return b;
  endfunction
  // byte to shift out for data byte idx of read op-code op
  function automatic logic [7:0] readByte(input logic [7:0] op,
                                          input logic [5:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (op)
      OP_RD_RX1_CTL: if (idx < CTL_BYTES) b = state.rx1Ctl;
      OP_RD_RX2_CTL: if (idx < CTL_BYTES) b = state.rx2Ctl;
      OP_RD_LABELS: if (idx < LABEL_BYTES) b = labelRdA;
      OP_RD_MATCH: if (idx < MATCH_BYTES) b = state.match[2'h2 - idx[1:0]];
      // first byte straight from the FIFO head
      OP_RD_MESSAGE: begin
        if (idx == 6'h00) begin
          b = fifoOutValid ? fifoOutData[31:24] : 8'h00;
        end else if (idx < MESSAGE_BYTES) begin
          b = wordByte(state.msgHold, idx[1:0]);
        end
      end
      // mailbox bits 9 to 32, number in op-code bits 3:2
      OP_RD_MBOX1, OP_RD_MBOX2, OP_RD_MBOX3: if (idx < MBOX_BYTES)
        b = wordByte({state.mbox[op[3:2] - 2'h1], 8'h00}, idx[1:0]);
      OP_RD_FLAGS: if (idx < CTL_BYTES) b = state.flags;
      OP_RD_DIVIDE: if (idx < CTL_BYTES) b = state.divide;
      // no-op and unknown codes send zeros
      default: b = 8'h00;
    endcase
    return b;
  endfunction
  // pin slots and edge detection on the agreeing stages two and three
  assign pinIn = {spiMosi, spiSelectN, spiClk};
  assign sckRise = (state.sync[PIN_SCK][1] == state.sync[PIN_SCK][2]) &&
                   state.sync[PIN_SCK][2] && !state.lvl[PIN_SCK];
  assign sckFall = (state.sync[PIN_SCK][1] == state.sync[PIN_SCK][2]) &&
                   !state.sync[PIN_SCK][2] && state.lvl[PIN_SCK];
  assign selected = !state.lvl[PIN_SEL];
  assign mosiBit = state.lvl[PIN_MOSI];
  assign fullByte = {state.rxShift, mosiBit};
  // label memory: host reads run one byte ahead so data is ready
  assign memAddrA = (state.phase == SP_DATA) ?
                    (state.dataIdx[4:0] + 5'h01) : 5'h00;
  assign rxLabelIn = rxWord[7:0];
  assign inLabel = state.rx2Ctl[CTL_RX_LABEL_BIT_REVERSE] ?
                   flipByte(rxLabelIn) : rxLabelIn;
  // label L sits in byte ~L[7:3], bit L[2:0]
  assign memAddrB = ~inLabel[7:3];
  assign sdOk = !state.rx2Ctl[CTL_SRC_DEST_DECODE_ENABLE] ||
                ((state.word[MSG_BIT_NINE] ==
                  state.rx2Ctl[CTL_MATCH_VALUE_BIT_NINE]) &&
                 (state.word[MSG_BIT_TEN] ==
                  state.rx2Ctl[CTL_MATCH_VALUE_BIT_TEN]));
  assign parityOk = !state.rx2Ctl[CTL_PARITY_CHECK] || (^state.word);
  assign labelOk = !state.rx2Ctl[CTL_LABEL_FILTER_ENABLE] ||
                   labelRdB[state.word[2:0]];
  assign acceptWord = sdOk && parityOk && labelOk;
  assign wordHigh = state.word[31:8];
  // outputs; stalled filter holds off the line decoder
  assign rxWordReady = (state.filt == FL_EMPTY);
  assign spiMisoOut = state.misoOut;
  assign spiMisoOeN = state.misoOeN;
  assign rx1Control = state.rx1Ctl;
  // rate select to the bit decoder
  assign rx2LowSpeed = state.rx2Ctl[CTL_LOW_RATE];
  assign flagAssign = state.flags;
  assign clockDivide = state.divide;
  // next-state logic: pin sync, host frame, filter
  always_comb begin
    next_state = state;
    memWrEn = 1'b0;
    memWrAddr = 5'h00;
    memWrData = 8'h00;
    fifoPop = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_state.sync[i] = {state.sync[i][1:0], pinIn[i]};
      if (state.sync[i][1] == state.sync[i][2]) begin
        next_state.lvl[i] = state.sync[i][2];
      end
    end
    // deselect aborts any frame; a partial byte is dropped
    if (!selected) begin
      next_state.phase = SP_OPCODE;
      next_state.bitCnt = 3'h0;
      next_state.dataIdx = 6'h00;
      next_state.txByte = 8'h00;
      next_state.misoOut = 1'b0;
      next_state.misoOeN = 1'b1;
    end else begin
      next_state.misoOeN = 1'b0;
      if (sckRise) begin
        next_state.rxShift = fullByte[6:0];
        next_state.bitCnt = state.bitCnt + 3'h1;
        if (state.bitCnt == 3'h7 && state.phase == SP_OPCODE) begin
          next_state.opcode = fullByte;
          next_state.phase = SP_DATA;
          next_state.txByte = readByte(fullByte, 6'h00);
          // whole word leaves the FIFO at op-code time
          if (fullByte == OP_RD_MESSAGE) begin
            fifoPop = fifoOutValid;
            next_state.msgHold = fifoOutValid ? fifoOutData : 32'h0;
          end
        end else if (state.bitCnt == 3'h7) begin
          // index saturates so bytes past the count stay zero
          next_state.dataIdx = (state.dataIdx == 6'h3f) ? 6'h3f :
                               state.dataIdx + 6'h01;
          next_state.txByte = readByte(state.opcode, next_state.dataIdx);
          case (state.opcode)
            OP_WR_RX1_CTL: if (state.dataIdx < CTL_BYTES) begin
              next_state.rx1Ctl = fullByte;
            end
            OP_WR_RX2_CTL: if (state.dataIdx < CTL_BYTES) begin
              next_state.rx2Ctl = fullByte;
            end
            // label bytes in descending label order
            OP_WR_LABELS: if (state.dataIdx < LABEL_BYTES) begin
              memWrEn = 1'b1;
              memWrAddr = state.dataIdx[4:0];
              memWrData = fullByte;
            end
            OP_WR_MATCH: if (state.dataIdx < MATCH_BYTES) begin
              next_state.match[2'h2 - state.dataIdx[1:0]] = fullByte;
            end
            OP_WR_FLAGS: if (state.dataIdx < CTL_BYTES) begin
              next_state.flags = fullByte;
            end
            OP_WR_DIVIDE: if (state.dataIdx < CTL_BYTES) begin
              next_state.divide = fullByte;
            end
            default: ;
          endcase
        end
      end
      // output changes on the falling edge, ready for the next rise
      if (sckFall) begin
        next_state.misoOut = state.txByte[7];
        next_state.txByte = {state.txByte[6:0], 1'b0};
      end
    end
    // filter: take, check one cycle later, then push or drop
    unique case (state.filt)
      FL_EMPTY: begin
        if (rxWordValid) begin
          next_state.word = {rxWord[31:8], inLabel};
          next_state.filt = FL_CHECK;
        end
      end
      FL_CHECK: begin
        for (int k = 0; k < 3; k++) begin
          if (state.rx2Ctl[CTL_PRIORITY_CAPTURE_ENABLE] && sdOk &&
              parityOk && state.word[7:0] == state.match[k]) begin
            next_state.mbox[k] = wordHigh;
          end
        end
        next_state.filt = acceptWord ? FL_PUSH : FL_EMPTY;
      end
      FL_PUSH: begin
        if (fifoInReady) begin
          next_state.filt = FL_EMPTY;
        end
      end
    endcase
  end
  // state register; controls reset to zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '0;
      state.sync[PIN_SEL] <= 3'h7;
      state.lvl <= PIN_IDLE;
      state.phase <= SP_OPCODE;
      state.misoOeN <= 1'b1;
      state.rx1Ctl <= CTL_RESET;
      state.rx2Ctl <= CTL_RESET;
      state.flags <= FLAGS_RESET;
      state.divide <= DIVIDE_RESET;
      state.filt <= FL_EMPTY;
    end else begin
      state <= next_state;
    end
  end
  // label acceptance bits
  arxf_label_mem #(.ENTRIES(32), .BITS(8)) labelMem (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddrA(memAddrA),
    .rdDataA(labelRdA),
    .rdAddrB(memAddrB),
    .rdDataB(labelRdB)
  );
  // accepted words wait here for the host
  arxf_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) wordFifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(state.filt == FL_PUSH),
    .inReady(fifoInReady),
    .inData(state.word),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );
  // checks on the filter and host decode
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    rxWordValid && rxWordReady;
  endsequence
  sequence s_check;
    state.filt == FL_CHECK;
  endsequence
  a_ctl_reset: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    rst |=> (state.rx1Ctl == 8'h00) && (state.rx2Ctl == 8'h00))
    else $error("control register not cleared by reset");
  a_label_flip: assert property (
    s_take ##0 state.rx2Ctl[CTL_RX_LABEL_BIT_REVERSE]
    |=> state.word[7:0] == flipByte($past(rxLabelIn)))
    else $error("stored label not bit reversed");
  a_bit_nine: assert property (
    s_check ##0 (state.rx2Ctl[CTL_SRC_DEST_DECODE_ENABLE] &&
    state.word[8] != state.rx2Ctl[6]) |=> state.filt == FL_EMPTY)
    else $error("word with wrong bit 9 accepted");
  a_bit_ten: assert property (
    s_check ##0 (state.rx2Ctl[CTL_SRC_DEST_DECODE_ENABLE] &&
    state.word[9] != state.rx2Ctl[5]) |=> state.filt == FL_EMPTY)
    else $error("word with wrong bit 10 accepted");
  a_all_off: assert property (
    s_take ##1 (state.rx2Ctl[4:2] == 3'h0) |=> state.filt == FL_PUSH)
    else $error("word dropped with every check disabled");
  a_parity_drop: assert property (
    s_check ##0 (state.rx2Ctl[CTL_PARITY_CHECK] && !(^state.word))
    |=> state.filt == FL_EMPTY)
    else $error("even parity word accepted");
  a_label_drop: assert property (
    s_check ##0 (state.rx2Ctl[CTL_LABEL_FILTER_ENABLE] &&
    !labelRdB[state.word[2:0]]) |=> state.filt == FL_EMPTY)
    else $error("word with rejected label accepted");
  a_mbox_capture: assert property (
    s_check ##0 (state.rx2Ctl[1] && sdOk && parityOk &&
    state.word[7:0] == state.match[0]) |=> state.mbox[0] == $past(wordHigh))
    else $error("matching word not captured in mailbox 1");
  a_mbox_quiet: assert property (
    !state.rx2Ctl[CTL_PRIORITY_CAPTURE_ENABLE] |=> $stable(state.mbox))
    else $error("mailbox written with priority capture off");
  a_nop_quiet: assert property (
    (state.phase == SP_DATA && state.opcode == OP_NOP) |-> !state.misoOut)
    else $error("no-op op-code drove data");
endmodule // arxf_rx_filter_control

// [bench/arxf_host_model.sv]
// arxf_host_model: host serial master, mode 0, msb first.
// assumes one caller at a time and pacing from ref_clk falls.
`timescale 1ns/1ps
module arxf_host_model (
  // pacing clock
  input wire logic ref_clk,
  // serial pins
  output logic spiClk,
  output logic spiSelectN,
  output logic spiMosi,
  input wire logic spiMisoOut,
  input wire logic spiMisoOeN
);
  logic [7:0] wb [32];
  logic [7:0] rb [32];
  // idle pins: clock low, not selected
  initial begin
    spiClk = 1'b0;
    spiSelectN = 1'b1;
    spiMosi = 1'b0;
  end
  // eight cycles a half period, 160 ns serial clock
  task automatic half();
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic xfer(input logic [7:0] op, input int nb);
    logic [7:0] sh;
    spiSelectN = 1'b0;
    for (int k = 0; k <= nb; k++) begin
      sh = (k == 0) ? op : wb[k-1];
      for (int b = 7; b >= 0; b--) begin
        spiMosi = sh[b];
        half();
        // undriven reply must never look like data
        if (k > 0) rb[k-1][b] = spiMisoOeN ? 1'bx : spiMisoOut;
        spiClk = 1'b1;
        half();
        spiClk = 1'b0;
      end
    end
    half();
    spiSelectN = 1'b1;
    spiMosi = ~spiMosi; // released line shows no stale bit
    half();
  endtask
endmodule // arxf_host_model

// [bench/testbench.sv]
// testbench: register reads, word filter, fifo and mailboxes.
// assumes arxf_host_model plays the serial host.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import arxf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic spiClk, spiSelectN, spiMosi, spiMisoOut, spiMisoOeN;
  logic [31:0] rxWord = 32'h0;
  logic rxWordValid = 1'b0;
  logic rxWordReady, rx2LowSpeed;
  logic [7:0] rx1Control, flagAssign, clockDivide, ctl, lab [32];
  logic [23:0] pv, m1;
  logic [31:0] w, q [$];
  int num_errors = 0;
  int n_checks = 0;
  assign pv = {rx1Control, flagAssign, clockDivide};
  always #5 ref_clk = ~ref_clk;
  arxf_rx_filter_control #(.FIFO_DEPTH(8)) u_arxf_rx_filter_control (
    .ref_clk(ref_clk), .rst(rst), .spiClk(spiClk),
    .spiSelectN(spiSelectN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN), .rxWord(rxWord), .rxWordValid(rxWordValid),
    .rxWordReady(rxWordReady), .rx1Control(rx1Control),
    .rx2LowSpeed(rx2LowSpeed), .flagAssign(flagAssign),
    .clockDivide(clockDivide));
  arxf_host_model hm (.ref_clk(ref_clk), .spiClk(spiClk),
    .spiSelectN(spiSelectN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN));
  // counts, verdict, end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-byte register write
  task automatic put(input logic [7:0] c, input logic [7:0] v);
    hm.wb[0] = v;
    hm.xfer(c, 1);
  endtask
  // offer a word; ready is read at a fall, so it is settled
  task automatic push(input logic [31:0] d, output bit ok);
    for (int i = 0; i < 100 && rxWordReady !== 1'b1; i++) @(negedge ref_clk);
    ok = (rxWordReady === 1'b1);
    if (ok) begin
      rxWordValid = 1'b1;
      rxWord = d;
      @(negedge ref_clk);
      rxWordValid = 1'b0;
      rxWord = ~d;
    end
  endtask
  // pop one word through the host port
  task automatic chk_word(input logic [31:0] e);
    hm.xfer(OP_RD_MESSAGE, 4);
    `CHK({hm.rb[0], hm.rb[1], hm.rb[2], hm.rb[3]}, e)
  endtask
  // expected word after optional label reversal
  function automatic logic [31:0] flip(input logic [31:0] x,
                                       input logic [7:0] c);
    flip = x;
    if (c[7]) for (int i = 0; i < 8; i++) flip[i] = x[7-i];
  endfunction
  // all enabled checks together decide storage
  function automatic bit pass(input logic [31:0] x, input logic [7:0] c);
    pass = (!c[4] || (x[8] == c[6] && x[9] == c[5])) && (!c[3] || ^x)
      && (!c[2] || lab[~x[7:3]][x[2:0]]);
  endfunction
  // slow frames put the expected run near 45k cycles
  initial begin
    #800000;
    num_errors++;
    finish_test();
  end
  initial begin
    bit ok;
    void'($urandom(48945));
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    hm.xfer(OP_RD_RX2_CTL, 1);
    `CHK(hm.rb[0], CTL_RESET)
    `CHK(pv, 24'h0)
    // one-byte registers, written then read back
    for (int i = 0; i < 3; i++) begin
      ctl = 8'($urandom);
      put(i == 0 ? OP_WR_RX1_CTL : i == 1 ? OP_WR_FLAGS : OP_WR_DIVIDE, ctl);
      hm.xfer(i == 0 ? OP_RD_RX1_CTL : i == 1 ? OP_RD_FLAGS : OP_RD_DIVIDE, 1);
      `CHK(hm.rb[0], ctl)
      `CHK(pv[23-8*i -: 8], ctl)
    end
    hm.xfer(OP_RD_RX2_CTL, 1);
    `CHK(hm.rb[0], CTL_RESET)
    $display("test registers done");
    for (int i = 0; i < 32; i++) begin
      lab[i] = 8'($urandom);
      hm.wb[i] = lab[i];
    end
    hm.xfer(OP_WR_LABELS, 32);
    hm.xfer(OP_RD_LABELS, 32);
    for (int i = 0; i < 32; i++) `CHK(hm.rb[i], lab[i])
    for (int i = 0; i < 3; i++) hm.wb[i] = 8'(8'h33 - 8'h11 * i);
    hm.xfer(OP_WR_MATCH, 3);
    hm.xfer(OP_RD_MATCH, 3);
    for (int i = 0; i < 3; i++) `CHK(hm.rb[i], 8'(8'h33 - 8'h11 * i))
    $display("test tables done");
    // random control and words, first one reversal only
    for (int n = 0; n < 24; n++) begin
      ctl = (n == 0) ? 8'h80 : 8'($urandom) & 8'hfd;
      put(OP_WR_RX2_CTL, ctl);
      `CHK(rx2LowSpeed, ctl[0])
      w = $urandom;
      push(w, ok);
      chk_word(pass(flip(w, ctl), ctl) ? flip(w, ctl) : 32'h0);
    end
    $display("test filter done");
    put(OP_WR_RX2_CTL, 8'h00);
    w = $urandom;
    push(w, ok);
    hm.xfer(OP_NOP, 4);
    `CHK({hm.rb[0], hm.rb[1], hm.rb[2], hm.rb[3]}, 32'h0)
    chk_word(w);
    $display("test no-op done");
    // fill until refused: eight queued plus one held
    for (int i = 0; i < 10; i++) begin
      w = $urandom;
      push(w, ok);
      if (ok) q.push_back(w);
    end
    `CHK(q.size(), 9)
    while (q.size() > 0) chk_word(q.pop_front());
    chk_word(32'h0);
    $display("test fifo done");
    put(OP_WR_RX2_CTL, 8'h02);
    for (int i = 1; i <= 4; i++) begin
      if (i == 4) put(OP_WR_RX2_CTL, 8'h00);
      w = {24'($urandom), 8'(8'h11 * (i == 4 ? 1 : i))};
      push(w, ok);
      if (i == 1) m1 = w[31:8];
      hm.xfer(8'(OP_RD_MBOX1 + 4 * (i == 4 ? 0 : i - 1)), 3);
      `CHK({hm.rb[0], hm.rb[1], hm.rb[2]}, i == 4 ? m1 : w[31:8])
    end
    $display("test mailboxes done");
    finish_test();
  end
endmodule // testbench
